// ### design/hst_consts.svh
/*
 constants for the halfword and signed transfer decoder: field positions,
 condition codes, sizes. assumes nothing; definitions only.
*/
`ifndef HST_CONSTS_SVH
`define HST_CONSTS_SVH
`define HST_COND_HI 31
`define HST_COND_LO 28
`define HST_PRE_BIT 24
`define HST_UP_BIT 23
`define HST_IMM_BIT 22
`define HST_WB_BIT 21
`define HST_LOAD_BIT 20
`define HST_RN_HI 19
`define HST_RN_LO 16
`define HST_RD_HI 15
`define HST_RD_LO 12
`define HST_OFFH_HI 11
`define HST_OFFH_LO 8
`define HST_MARK7_BIT 7
`define HST_SH_HI 6
`define HST_SH_LO 5
`define HST_MARK4_BIT 4
`define HST_OFFL_HI 3
`define HST_OFFL_LO 0
`define HST_CLASS_HI 27
`define HST_CLASS_LO 25
`define HST_CLASS_VAL 3'h0
`define HST_SH_SWAP 2'h0
`define HST_SH_UHALF 2'h1
`define HST_SH_SBYTE 2'h2
`define HST_SH_SHALF 2'h3
`define HST_FLAG_N 3
`define HST_FLAG_Z 2
`define HST_FLAG_C 1
`define HST_FLAG_V 0
`define HST_ADDR_HALF_BIT 1
`define HST_ZERO16 16'h0000
`endif

// ### design/hst_decode.sv
/*
 halfword and signed data transfer decoder and executor.
 assumes: one instruction offered with i_valid/o_ready; register values
 come in beside the instruction; memory answers a read with i_mem_done
 and its data in that cycle; writes complete on i_mem_done too.
*/
`timescale 1ns/1ps
`include "hst_consts.svh"
module hst_decode
   import hst_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // instruction from fetch
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [31:0] i_instr,
   input wire logic [3:0] i_flags,
   // register file values for the named fields
   input wire logic [31:0] i_base_val,
   input wire logic [31:0] i_index_val,
   input wire logic [31:0] i_src_val,
   // configuration
   input wire logic i_endian_select_input,
   // memory side
   output logic o_mem_req,
   output logic o_mem_write,
   output logic [31:0] o_mem_addr,
   output logic [31:0] o_mem_wdata,
   input wire logic i_mem_done,
   input wire logic [31:0] i_mem_rdata,
   // register write ports
   output logic o_rd_we,
   output logic [3:0] o_rd_sel,
   output logic [31:0] o_rd_data,
   output logic o_base_we,
   output logic [3:0] o_base_sel,
   output logic [31:0] o_base_data,
   // decode status
   output logic o_skipped,
   output logic o_not_mine
);
   // =====================================================
   // state
   typedef struct packed {
      hst_state_t st;
      hst_kind_t kind;
      logic load;
      logic [3:0] rd;
      logic [3:0] rn;
      logic base_wb;
      logic [31:0] new_base;
      logic mem_req;
      logic mem_write;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic rd_we;
      logic [31:0] rd_data;
      logic base_we;
      logic [31:0] base_data;
      logic skipped;
      logic not_mine;
   } hst_regs_t;

   hst_regs_t q_r, q_nxt;

   // =====================================================
   // helpers
   function automatic logic cond_true(input logic [3:0] c,
                                      input logic [3:0] f);
      logic n, z, cy, v;
      n = f[`HST_FLAG_N];
      z = f[`HST_FLAG_Z];
      cy = f[`HST_FLAG_C];
      v = f[`HST_FLAG_V];
      unique case (c)
         4'h0: cond_true = z;
         4'h1: cond_true = !z;
         4'h2: cond_true = cy;
         4'h3: cond_true = !cy;
         4'h4: cond_true = n;
         4'h5: cond_true = !n;
         4'h6: cond_true = v;
         4'h7: cond_true = !v;
         4'h8: cond_true = cy && !z;
         4'h9: cond_true = !cy || z;
         4'ha: cond_true = n == v;
         4'hb: cond_true = n != v;
         4'hc: cond_true = !z && (n == v);
         4'hd: cond_true = z || (n != v);
         4'he: cond_true = 1'b1;
         4'hf: cond_true = 1'b0;
      endcase
   endfunction

   logic [3:0] f_cond;
   logic f_pre, f_up, f_imm, f_wb, f_load;
   logic [1:0] f_sh;
   logic is_class, exec;
   logic [7:0] imm8;
   logic [31:0] offset, moved, xfer_addr;
   hst_kind_t kind_d;
   logic [31:0] load_val;

   always_comb begin
      f_cond = i_instr[`HST_COND_HI:`HST_COND_LO];
      f_pre = i_instr[`HST_PRE_BIT];
      f_up = i_instr[`HST_UP_BIT];
      f_imm = i_instr[`HST_IMM_BIT];
      f_wb = i_instr[`HST_WB_BIT];
      f_load = i_instr[`HST_LOAD_BIT];
      f_sh = i_instr[`HST_SH_HI:`HST_SH_LO];
      // swap and unmarked encodings fall outside this class
      is_class = (i_instr[`HST_CLASS_HI:`HST_CLASS_LO] == `HST_CLASS_VAL)
         && i_instr[`HST_MARK7_BIT] && i_instr[`HST_MARK4_BIT]
         && (f_sh != `HST_SH_SWAP);
      unique case (f_sh)
         `HST_SH_UHALF: kind_d = HST_K_UHALF;
         `HST_SH_SBYTE: kind_d = HST_K_SBYTE;
         `HST_SH_SHALF: kind_d = HST_K_SHALF;
         `HST_SH_SWAP: kind_d = HST_K_NONE;
      endcase
      // stores of signed kinds are not defined; treat as halfword store
      exec = is_class && cond_true(f_cond, i_flags);
      imm8 = {i_instr[`HST_OFFH_HI:`HST_OFFH_LO],
              i_instr[`HST_OFFL_HI:`HST_OFFL_LO]};
      offset = f_imm ? {24'h0, imm8} : i_index_val;
      moved = f_up ? i_base_val + offset
                   : i_base_val - offset;
      xfer_addr = f_pre ? moved : i_base_val;
   end

   hst_lane u_lane (
      .i_kind(q_r.kind),
      .i_endian_select_input(i_endian_select_input),
      .i_addr_lo(q_r.mem_addr[1:0]),
      .i_rdata(i_mem_rdata),
      .o_value(load_val)
   );

   // =====================================================
   // next state
   always_comb begin
      q_nxt = q_r;
      q_nxt.rd_we = 1'b0;
      q_nxt.base_we = 1'b0;
      q_nxt.skipped = 1'b0;
      q_nxt.not_mine = 1'b0;
      unique case (q_r.st)
         HST_IDLE: begin
            if (i_valid) begin
               if (!is_class) begin
                  q_nxt.not_mine = 1'b1;
               end else if (!exec) begin
                  q_nxt.skipped = 1'b1;
               end else begin
                  q_nxt.st = HST_WAIT;
                  q_nxt.kind = f_load ? kind_d : HST_K_UHALF;
                  q_nxt.load = f_load;
                  q_nxt.rd = i_instr[`HST_RD_HI:`HST_RD_LO];
                  q_nxt.rn = i_instr[`HST_RN_HI:`HST_RN_LO];
                  // post-index ignores the write-back bit entirely
                  q_nxt.base_wb = f_pre ? f_wb : 1'b1;
                  q_nxt.new_base = moved;
                  q_nxt.mem_req = 1'b1;
                  q_nxt.mem_write = !f_load;
                  q_nxt.mem_addr = xfer_addr;
                  q_nxt.mem_wdata = {i_src_val[15:0],
                                     i_src_val[15:0]};
               end
            end
         end
         HST_WAIT: begin
            if (i_mem_done) begin
               q_nxt.st = HST_IDLE;
               q_nxt.mem_req = 1'b0;
               q_nxt.mem_write = 1'b0;
               q_nxt.base_we = q_r.base_wb;
               q_nxt.base_data = q_r.new_base;
               q_nxt.rd_we = q_r.load;
               q_nxt.rd_data = load_val;
            end
         end
         default: q_nxt.st = HST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // =====================================================
   // outputs
   assign o_ready = (q_r.st == HST_IDLE);
   assign o_mem_req = q_r.mem_req;
   assign o_mem_write = q_r.mem_write;
   assign o_mem_addr = q_r.mem_addr;
   assign o_mem_wdata = q_r.mem_wdata;
   assign o_rd_we = q_r.rd_we;
   assign o_rd_sel = q_r.rd;
   assign o_rd_data = q_r.rd_data;
   assign o_base_we = q_r.base_we;
   assign o_base_sel = q_r.rn;
   assign o_base_data = q_r.base_data;
   assign o_skipped = q_r.skipped;
   assign o_not_mine = q_r.not_mine;

   // =====================================================
   // checks
   logic take;
   assign take = i_valid && o_ready;

   sequence s_issue;
      take && exec;
   endsequence

   property p_cond_skip;
      @(posedge i_clk) disable iff (i_reset)
      take && is_class && !exec |=> o_skipped && !o_mem_req;
   endproperty
   a_cond_skip: assert property (p_cond_skip)
      else $error("failed condition still issued a transfer");

   property p_imm_addr;
      @(posedge i_clk) disable iff (i_reset)
      s_issue and (f_imm && f_pre && f_up) |=>
         o_mem_addr == $past(i_base_val) + {24'h0,
         $past(i_instr[`HST_OFFH_HI:`HST_OFFH_LO]),
         $past(i_instr[`HST_OFFL_HI:`HST_OFFL_LO])};
   endproperty
   a_imm_addr: assert property (p_imm_addr)
      else $error("immediate pre-index address wrong");

   property p_down;
      @(posedge i_clk) disable iff (i_reset)
      s_issue and (!f_imm && f_pre && !f_up) |=>
         o_mem_addr == $past(i_base_val) - $past(i_index_val);
   endproperty
   a_down: assert property (p_down)
      else $error("down index did not subtract");

   sequence s_done;
      q_r.st == HST_WAIT && i_mem_done;
   endsequence

   // retiring frees the decoder and writes the destination only on loads
   property p_retire;
      @(posedge i_clk) disable iff (i_reset)
      s_done |=> o_ready && !o_mem_req && o_rd_we == $past(q_r.load);
   endproperty
   a_retire: assert property (p_retire)
      else $error("transfer did not retire cleanly");

   property p_post_addr;
      @(posedge i_clk) disable iff (i_reset)
      s_issue and !f_pre |=> o_mem_addr == $past(i_base_val);
   endproperty
   a_post_addr: assert property (p_post_addr)
      else $error("post index did not use the base");

   property p_wb;
      @(posedge i_clk) disable iff (i_reset)
      q_r.st == HST_WAIT && i_mem_done |=>
         o_base_we == q_r.base_wb && o_base_data == $past(q_r.new_base);
   endproperty
   a_wb: assert property (p_wb)
      else $error("base write-back mismatch");

   property p_post_wb;
      @(posedge i_clk) disable iff (i_reset)
      s_issue and !f_pre |=> q_r.base_wb;
   endproperty
   a_post_wb: assert property (p_post_wb)
      else $error("post index must write back");

   property p_store_data;
      @(posedge i_clk) disable iff (i_reset)
      s_issue and !f_load |=> o_mem_write &&
         o_mem_wdata[31:16] == o_mem_wdata[15:0] &&
         o_mem_wdata[15:0] == $past(i_src_val[15:0]);
   endproperty
   a_store_data: assert property (p_store_data)
      else $error("halfword store data not repeated");

   property p_uhalf_zero;
      @(posedge i_clk) disable iff (i_reset)
      q_r.st == HST_WAIT && q_r.load && q_r.kind == HST_K_UHALF &&
         i_mem_done |=> o_rd_we && o_rd_data[31:16] == 16'h0000;
   endproperty
   a_uhalf_zero: assert property (p_uhalf_zero)
      else $error("unsigned halfword not zero filled");

   property p_le_lane;
      @(posedge i_clk) disable iff (i_reset)
      q_r.st == HST_WAIT && q_r.kind == HST_K_UHALF && q_r.load &&
         !i_endian_select_input && i_mem_done |=>
         o_rd_data[15:0] == ($past(q_r.mem_addr[1]) ?
         $past(i_mem_rdata[31:16]) : $past(i_mem_rdata[15:0]));
   endproperty
   a_le_lane: assert property (p_le_lane)
      else $error("little endian lane wrong");

   property p_be_lane;
      @(posedge i_clk) disable iff (i_reset)
      q_r.st == HST_WAIT && q_r.kind == HST_K_UHALF && q_r.load &&
         i_endian_select_input && i_mem_done |=>
         o_rd_data[15:0] == ($past(q_r.mem_addr[1]) ?
         $past(i_mem_rdata[15:0]) : $past(i_mem_rdata[31:16]));
   endproperty
   a_be_lane: assert property (p_be_lane)
      else $error("big endian lane wrong");

   property p_swap_out;
      @(posedge i_clk) disable iff (i_reset)
      take && f_sh == `HST_SH_SWAP |=> o_not_mine && !o_mem_req;
   endproperty
   a_swap_out: assert property (p_swap_out)
      else $error("swap encoding was executed");

   property p_imm_down;
      @(posedge i_clk) disable iff (i_reset)
      s_issue and (f_imm && f_pre && !f_up) |=>
         o_mem_addr == $past(i_base_val) - {24'h0,
         $past(i_instr[`HST_OFFH_HI:`HST_OFFH_LO]),
         $past(i_instr[`HST_OFFL_HI:`HST_OFFL_LO])};
   endproperty
   a_imm_down: assert property (p_imm_down)
      else $error("immediate down index did not subtract");

   // a waiting request must not wander while memory works on it
   property p_wait_hold;
      @(posedge i_clk) disable iff (i_reset)
      q_r.st == HST_WAIT && !i_mem_done |=>
         o_mem_req && !o_ready && $stable(o_mem_addr);
   endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("request changed while waiting");

   property p_sbyte_sign;
      @(posedge i_clk) disable iff (i_reset)
      s_done and (q_r.load && q_r.kind == HST_K_SBYTE) |=>
         o_rd_we && o_rd_data[31:8] == {24{o_rd_data[7]}};
   endproperty
   a_sbyte_sign: assert property (p_sbyte_sign)
      else $error("signed byte not sign extended");

   property p_shalf_sign;
      @(posedge i_clk) disable iff (i_reset)
      s_done and (q_r.load && q_r.kind == HST_K_SHALF) |=>
         o_rd_we && o_rd_data[31:16] == {16{o_rd_data[15]}};
   endproperty
   a_shalf_sign: assert property (p_shalf_sign)
      else $error("signed halfword not sign extended");
endmodule

// ### design/hst_lane.sv
/*
 load data lane selection and extension for halfword and byte loads.
 assumes a 32-bit read data bus and address low bits of the transfer.
*/
`timescale 1ns/1ps
`include "hst_consts.svh"
module hst_lane
   import hst_pkg::*;
(
   // selection
   input wire hst_kind_t i_kind,
   input wire logic i_endian_select_input,
   input wire logic [1:0] i_addr_lo,
   // data
   input wire logic [31:0] i_rdata,
   output logic [31:0] o_value
);
   logic [15:0] half;
   logic [7:0] byte_v;
   logic hi_half;
   logic [1:0] bidx;
   always_comb begin
      // big endian flips which half the aligned address names
      hi_half = i_addr_lo[`HST_ADDR_HALF_BIT] ^ i_endian_select_input;
      half = hi_half ? i_rdata[31:16] : i_rdata[15:0];
      bidx = i_endian_select_input ? ~i_addr_lo : i_addr_lo;
      byte_v = i_rdata[{bidx, 3'h0} +: 8];
      unique case (i_kind)
         HST_K_UHALF: o_value = {`HST_ZERO16, half};
         HST_K_SHALF: o_value = {{16{half[15]}}, half};
         HST_K_SBYTE: o_value = {{24{byte_v[7]}}, byte_v};
         HST_K_NONE: o_value = 32'h0;
      endcase
   end
endmodule

// ### design/hst_pkg.sv
/*
 types for the halfword and signed transfer decoder.
 assumes hst_consts.svh holds the numbers.
*/
package hst_pkg;
   typedef enum logic [1:0] {HST_IDLE, HST_WAIT} hst_state_t;
   typedef enum logic [1:0] {
      HST_K_NONE, HST_K_UHALF, HST_K_SBYTE, HST_K_SHALF
   } hst_kind_t;
endpackage

// ### dv/halfword_signed_transfer_decode_tb_top.sv
/*
 self-checking bench for the halfword and signed transfer decoder.
 assumes hst_decode and hst_mem_model; one instruction at a time.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module halfword_signed_transfer_decode_tb_top;
   // ==========================================
   // stimulus and observation
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_valid = 1'b0;
   logic i_endian_select_input = 1'b0;
   logic [31:0] i_instr = 32'h0, i_base_val = 32'h0;
   logic [31:0] i_index_val = 32'h0, i_src_val = 32'h0, mword = 32'h0;
   logic [3:0] i_flags = 4'h0, mdelay = 4'h0;
   logic o_ready, o_mem_req, o_mem_write, i_mem_done, o_rd_we, o_base_we;
   logic o_skipped, o_not_mine;
   logic [31:0] o_mem_addr, o_mem_wdata, i_mem_rdata, o_rd_data;
   logic [31:0] o_base_data, m_wdata;
   logic [3:0] o_rd_sel, o_base_sel;
   int fails = 0, n_checks = 0;
   always #50 i_clk = ~i_clk;
   hst_decode i_hst_decode (.i_clk(i_clk), .i_reset(i_reset),
      .i_valid(i_valid), .o_ready(o_ready), .i_instr(i_instr),
      .i_flags(i_flags), .i_base_val(i_base_val),
      .i_index_val(i_index_val), .i_src_val(i_src_val),
      .i_endian_select_input(i_endian_select_input),
      .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
      .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
      .i_mem_done(i_mem_done), .i_mem_rdata(i_mem_rdata),
      .o_rd_we(o_rd_we), .o_rd_sel(o_rd_sel), .o_rd_data(o_rd_data),
      .o_base_we(o_base_we), .o_base_sel(o_base_sel),
      .o_base_data(o_base_data), .o_skipped(o_skipped),
      .o_not_mine(o_not_mine));
   hst_mem_model i_hst_mem_model (.i_clk(i_clk), .i_reset(i_reset),
      .i_mem_req(o_mem_req), .i_mem_wdata(o_mem_wdata),
      .o_mem_done(i_mem_done), .o_mem_rdata(i_mem_rdata),
      .i_delay(mdelay), .i_word(mword), .o_last_wdata(m_wdata));
   // ==========================================
   // helpers
   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
      logic r;
      case (c[3:1])
         3'h0: r = f[2];
         3'h1: r = f[1];
         3'h2: r = f[3];
         3'h3: r = f[0];
         3'h4: r = f[1] && !f[2];
         3'h5: r = f[3] == f[0];
         3'h6: r = !f[2] && f[3] == f[0];
         default: r = 1'b1;
      endcase
      // odd codes invert the even ones; the top code never runs
      return (c == 4'hf) ? 1'b0 : (c == 4'he) ? 1'b1 : r ^ c[0];
   endfunction
   function automatic logic [31:0] mk(input logic [3:0] c,
      input logic [4:0] puiwl, input logic [1:0] sh, input logic [7:0] off);
      return {c, 3'h0, puiwl, 4'h3, 4'h9, puiwl[2] ? off[7:4] : 4'h0,
         1'b1, sh, 1'b1, off[3:0]};
   endfunction
   task automatic conclude;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic xfer(input logic [31:0] ins, input logic [31:0] base,
      input logic [31:0] idx, input logic [31:0] src, input logic [3:0] fl);
      logic [31:0] off, nb, adr, ev, c_addr, c_rd, c_bd, c_wd;
      logic [15:0] hw;
      logic [7:0] by;
      logic nm, ex, wb, c_req, c_wr, c_rwe, c_bwe, c_skip, c_nm;
      logic [3:0] c_rsel, c_bsel;
      int bi, k;
      // expectations read endian and memory word once they have settled
      @(posedge i_clk);
      nm = ins[27:25] != 3'h0 || ins[6:5] == 2'h0 || !(ins[7] && ins[4]);
      ex = !nm && cond_ok(ins[31:28], fl);
      off = ins[22] ? {24'h0, ins[11:8], ins[3:0]} : idx;
      nb = ins[23] ? base + off : base - off;
      adr = ins[24] ? nb : base;
      wb = !ins[24] || ins[21];
      hw = (adr[1] ^ i_endian_select_input) ? mword[31:16] : mword[15:0];
      bi = i_endian_select_input ? 3 - int'(adr[1:0]) : int'(adr[1:0]);
      by = mword[8 * bi +: 8];
      case (ins[6:5])
         2'h1: ev = {16'h0, hw};
         2'h2: ev = {{24{by[7]}}, by};
         default: ev = {{16{hw[15]}}, hw};
      endcase
      {c_req, c_rwe, c_bwe, c_skip, c_nm} = 5'h0;
      i_valid <= 1'b1;
      i_instr <= ins;
      i_flags <= fl;
      i_base_val <= base;
      i_index_val <= idx;
      i_src_val <= src;
      @(posedge i_clk);
      i_valid <= 1'b0;
      for (k = 0; k < 40; k++) begin
         #1;
         if (o_mem_req === 1'b1) begin
            c_req = 1'b1;
            {c_addr, c_wr, c_wd} = {o_mem_addr, o_mem_write, o_mem_wdata};
         end
         if (o_rd_we === 1'b1) {c_rwe, c_rd, c_rsel} = {1'b1, o_rd_data, o_rd_sel};
         if (o_base_we === 1'b1)
            {c_bwe, c_bd, c_bsel} = {1'b1, o_base_data, o_base_sel};
         c_skip = c_skip | (o_skipped === 1'b1);
         c_nm = c_nm | (o_not_mine === 1'b1);
         if (o_ready === 1'b1)
            break;
         @(posedge i_clk);
      end
      `CHK(o_ready, 1'b1)
      `CHK(c_nm, nm)
      `CHK(c_skip, !nm && !ex)
      `CHK(c_req, ex)
      if (ex) begin
         `CHK(c_addr, adr)
         `CHK(c_wr, !ins[20])
         `CHK(c_rwe, ins[20])
         `CHK(c_bwe, wb)
         if (wb) begin
            `CHK(c_bd, nb)
            `CHK(c_bsel, ins[19:16])
         end
         if (ins[20]) begin
            `CHK(c_rd, ev)
            `CHK(c_rsel, ins[15:12])
         end else begin
            `CHK(c_wd, {src[15:0], src[15:0]})
            `CHK(m_wdata, {src[15:0], src[15:0]})
         end
      end
   endtask
   // ==========================================
   // tests
   initial begin
      int m, f;
      int flip [4] = '{5, 25, 7, 4};
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      mword <= 32'h7e81_8a3c;
      for (m = 0; m < 32; m++) begin
         i_endian_select_input <= m[4];
         mdelay <= 4'(m % 3 * 3);
         // post forms keep write-back clear
         xfer(mk(4'he, {m[3], m[2], m[1], m[3] & (m[1] ^ m[0]), m[0]},
            2'(m % 3 + 1), 8'hc6 - 8'(m * 2)), 32'h2000_0040 + 32'(m * 2),
            32'h0000_0132, 32'hc3a5_96f0 ^ 32'(m), 4'h0);
      end
      $display("test modes done");
      for (m = 0; m < 16; m++)
         for (f = 0; f < 16; f += 5)
            xfer(mk(4'(m), 5'h18, 2'h1, 8'h04), 32'h100, 32'h0,
               32'h1234_abcd, 4'(f));
      $display("test conditions done");
      for (m = 0; m < 4; m++)
         xfer(mk(4'he, 5'h18, 2'h1, 8'h04) ^ (32'h1 << flip[m]), 32'h100,
            32'h0, 32'h0, 4'h0);
      $display("test foreign done");
      mdelay <= 4'h8;
      @(posedge i_clk);
      i_valid <= 1'b1;
      i_instr <= mk(4'he, 5'h19, 2'h1, 8'h02);
      @(posedge i_clk);
      i_valid <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b1;
      @(posedge i_clk);
      i_reset <= 1'b0;
      #1;
      `CHK(o_mem_req, 1'b0)
      `CHK(o_ready, 1'b1)
      mdelay <= 4'h1;
      xfer(mk(4'he, 5'h17, 2'h3, 8'h10), 32'h8000, 32'h0, 32'h0, 4'h0);
      $display("test reset done");
      conclude();
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      fails++;
      conclude();
   end
endmodule

// ### dv/hst_mem_model.sv
/*
 memory system model for the halfword and signed transfer decoder.
 assumes the request holds steady until done and drops the cycle after.
*/
`timescale 1ns/1ps
module hst_mem_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // memory side of the decoder
   input wire logic i_mem_req,
   input wire logic [31:0] i_mem_wdata,
   output logic o_mem_done = 1'b0,
   output logic [31:0] o_mem_rdata,
   // scenario control
   input wire logic [3:0] i_delay,
   input wire logic [31:0] i_word,
   output logic [31:0] o_last_wdata
);
   // ==========================================
   // response
   logic [3:0] cnt_r;
   logic served_r;
   // bus is released outside done: show the inverse, never stale data
   assign o_mem_rdata = o_mem_done ? i_word : ~i_word;
   always @(posedge i_clk) begin
      o_mem_done <= 1'b0;
      if (i_reset || !i_mem_req) begin
         cnt_r <= 4'h0;
         served_r <= 1'b0;
      end else if (!served_r && cnt_r == i_delay) begin
         o_mem_done <= 1'b1;
         served_r <= 1'b1;
         o_last_wdata <= i_mem_wdata;
      end else if (!served_r) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule
